/* File: rtl/tws_core.v */
// Two-wire bus master/slave controller with APB register access
//
// Behaviour
// [RQ1] Writing master, transmitter and busy set while bus free sends start plus byte.
// [RQ2] Software loads the byte and sets acknowledge mode before a start.
// [RQ3] Master, transmitter, pending set with busy cleared while busy starts a stop.
// [RQ4] Software keeps those bits unchanged until the stop appears on the bus.
// [RQ5] Busy flag sets on any start seen and clears on any stop seen.
// [RQ6] Master interrupts after the counted bits plus optional acknowledge clock.
// [RQ7] Slave interrupts on own address, general call, or word after a match.
// [RQ8] Interrupt clears pending flag; clock line held low while it is zero.
// [RQ9] Buffer access sets pending; clock released one low period later.
// [RQ10] Writing one sets pending; writing zero leaves it alone.
// [RQ11] Mode field value 10 selects two-wire operation; set with pins high.
// [RQ12] Transmitting master compares data line at clock rise; mismatch sets lost flag.
// [RQ13] A master that lost arbitration releases both lines.
// [RQ14] Lost arbitration clears master and transmitter, giving slave receiver.
// [RQ15] Buffer access or control-two write clears the lost flag.
// [RQ16] Address match flag sets on own address, general call or first free word.
// [RQ17] General call flag sets on all-zero first byte; start or stop clears it.
// [RQ18] Last received bit samples the data line at every clock rise.
// [RQ19] Software reset bit pulses an internal reset and reads back zero.
// [RQ20] Software initialises acknowledge, counts, rate, address, then slave receiver mode.
// [RQ21] Address launch interrupts at ninth fall; direction updates transmitter if acknowledged.
// [RQ22] Software rechecks bus free within 98.0 us of loading the address.
// [RQ23] Bit count forced to zero at each start, else kept.
// [RQ24] Master acknowledge clock: release data when sending, pull low when receiving.
// [RQ25] After any reset busy reads zero and neither line is driven.
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_core (
    input  wire        clk,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        scl_in,
    output reg         scl_out,
    output reg         scl_oe,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    output reg         bus_interrupt_request
);
    localparam [6:0] S_IDLE  = 7'h01;
    localparam [6:0] S_START = 7'h02;
    localparam [6:0] S_LOW   = 7'h04;
    localparam [6:0] S_HIGH  = 7'h08;
    localparam [6:0] S_STP1  = 7'h10;
    localparam [6:0] S_STP2  = 7'h20;
    localparam [6:0] S_STP3  = 7'h40;

    wire       rst_n;
    wire       core_rst_n;
    wire [1:0] lines;
    reg        srst;
    reg  [2:0] bit_count_field;
    reg        ack;
    reg  [2:0] sck;
    reg  [7:0] data_buffer;
    reg  [6:0] own_address_field;
    reg        address_recognition_disable;
    reg        master_select;
    reg        transmitter_select;
    reg        bus_busy_flag;
    reg        pin;
    reg  [1:0] operating_mode_field;
    reg        arbitration_lost_flag;
    reg        address_match_flag;
    reg        general_call_flag;
    reg        last_received_bit;
    reg        addressed;
    reg        first_word;
    reg  [3:0] bitn;
    reg        stop_req;
    reg        slv_hold;
    reg  [9:0] hcnt;
    reg  [6:0] state;
    reg  [9:0] cnt;
    reg        scl_p;
    reg        sda_p;
    reg        next_sda;
    reg  [7:0] rdv;

    // ============================================================
    // Reset and pin synchronisers
    tws_sync #(.W(1), .RV(1'b0)) u_rst (
        .clk   (clk),
        .rst_n (resetn),
        .d     (1'b1),
        .q     (rst_n)
    );

    // [RQ19] Software reset pulse
    assign core_rst_n = rst_n & ~srst;

    tws_sync #(.W(2), .RV(2'h3)) u_pins (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({scl_in, sda_in}),
        .q     (lines)
    );

    wire scl_s = lines[1];
    wire sda_s = lines[0];

    // ============================================================
    // Bus event decode
    // [RQ11] Active only in two-wire mode
    wire on       = (operating_mode_field == `TWS_MODE_I2C);
    wire scl_rise = on & scl_s & ~scl_p;
    wire scl_fall = on & ~scl_s & scl_p;
    wire st_det   = on & scl_s & scl_p & sda_p & ~sda_s;
    wire sp_det   = on & scl_s & scl_p & ~sda_p & sda_s;

    wire [3:0] dlen  = (bit_count_field == 3'h0) ? 4'h8 : {1'b0, bit_count_field};
    wire [3:0] wlen  = dlen + {3'h0, ack};
    wire [9:0] half  = `TWS_HALF_MIN << sck;
    wire [9:0] last  = half - 10'h001;
    wire       match = (data_buffer[7:1] == own_address_field) | (data_buffer == `TWS_GCALL);
    wire       ack_ok = master_select | (first_word ? (address_recognition_disable | match)
                                                    : (addressed | address_recognition_disable));

    // [RQ12] Mismatch on a transmitted one
    wire lose = scl_rise & bus_busy_flag & master_select & transmitter_select &
                (bitn < dlen) & ~sda_oe & ~sda_s;

    // ============================================================
    // APB decode
    wire acc    = psel & penable & pready;
    wire wr     = acc & pwrite;
    wire a_ctl1 = (paddr == `TWS_A_CTL1);
    wire a_dbuf = (paddr == `TWS_A_DBUF);
    wire a_oar  = (paddr == `TWS_A_OAR);
    wire a_ctl2 = (paddr == `TWS_A_CTL2);
    wire a_creg = (paddr == `TWS_A_CREG);
    wire hit    = a_ctl1 | a_dbuf | a_oar | a_ctl2 | a_creg;

    // [RQ1] Start command while bus free
    wire start_cmd = wr & a_ctl2 & ~bus_busy_flag & pwdata[`TWS_B_MST] &
                     pwdata[`TWS_B_TRX] & pwdata[`TWS_B_BB];
    // [RQ3] Stop command while bus busy
    wire stop_cmd  = wr & a_ctl2 & bus_busy_flag & pwdata[`TWS_B_MST] &
                     pwdata[`TWS_B_TRX] & pwdata[`TWS_B_PIN] & ~pwdata[`TWS_B_BB];

    always @* begin
        case (paddr)
            `TWS_A_CTL1: rdv = {bit_count_field, ack, 1'b0, sck};
            `TWS_A_DBUF: rdv = data_buffer;
            `TWS_A_OAR:  rdv = {own_address_field, address_recognition_disable};
            `TWS_A_CTL2: rdv = {master_select, transmitter_select, bus_busy_flag, pin,
                                arbitration_lost_flag, address_match_flag,
                                general_call_flag, last_received_bit};
            default:     rdv = 8'h00;
        endcase
    end

    // ============================================================
    // APB slave, one wait state
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            srst    <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel & penable & ~pready) begin
                prdata  <= pwrite ? 32'h00000000 : {24'h000000, rdv};
                pslverr <= ~hit;
            end
            // [RQ19] Self-clearing reset bit
            srst <= wr & a_creg & pwdata[`TWS_B_SOFTWARE_RESET_BIT];
        end
    end

    // ============================================================
    // Drive level for the next bit
    always @* begin
        next_sda = 1'b0;
        if (bitn < dlen)
            next_sda = transmitter_select & ~data_buffer[7] &
                       (master_select | addressed | address_recognition_disable);
        // [RQ24] Acknowledge slot
        else if ((bitn == dlen) & ack)
            next_sda = ~transmitter_select & ack_ok;
    end

    // ============================================================
    // Master clock sequencer
    always @(posedge clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            state <= S_IDLE;
            cnt   <= 10'h000;
        // [RQ13] Lost master drops its clock
        end else if (~on | lose | (~master_select & (state == S_LOW))) begin
            state <= S_IDLE;
            cnt   <= 10'h000;
        end else begin
            case (state)
                S_IDLE: begin
                    // [RQ2] Buffer already loaded
                    if (start_cmd) begin
                        state <= S_START;
                        cnt   <= 10'h000;
                    end
                end
                S_START: begin
                    if (cnt == last) begin
                        state <= S_LOW;
                        cnt   <= 10'h000;
                    end else begin
                        cnt <= cnt + 10'h001;
                    end
                end
                S_LOW: begin
                    if (scl_s)
                        cnt <= 10'h000;
                    else if (cnt != last)
                        cnt <= cnt + 10'h001;
                    // [RQ9] Leave low only once hold ends
                    else if (pin & ~slv_hold) begin
                        state <= stop_req ? S_STP1 : S_HIGH;
                        cnt   <= 10'h000;
                    end
                end
                S_HIGH: begin
                    if (scl_s) begin
                        if (cnt == last) begin
                            state <= S_LOW;
                            cnt   <= 10'h000;
                        end else begin
                            cnt <= cnt + 10'h001;
                        end
                    end else if (cnt != 10'h000) begin
                        state <= S_LOW;
                        cnt   <= 10'h000;
                    end
                end
                S_STP1: begin
                    if (cnt == last) begin
                        state <= S_STP2;
                        cnt   <= 10'h000;
                    end else begin
                        cnt <= cnt + 10'h001;
                    end
                end
                S_STP2: begin
                    if (scl_s & (cnt == last)) begin
                        state <= S_STP3;
                        cnt   <= 10'h000;
                    end else if (scl_s) begin
                        cnt <= cnt + 10'h001;
                    end
                end
                S_STP3: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                    cnt   <= 10'h000;
                end
            endcase
        end
    end

    // ============================================================
    // Registers, bit engine and status
    always @(posedge clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            bit_count_field             <= `TWS_R_BC;
            ack                         <= `TWS_R_ACK;
            sck                         <= `TWS_R_SCK;
            data_buffer                 <= `TWS_R_DBUF;
            own_address_field           <= `TWS_R_SA;
            address_recognition_disable <= `TWS_R_ALS;
            operating_mode_field        <= `TWS_R_MODE;
            master_select               <= 1'b0;
            transmitter_select          <= 1'b0;
            // [RQ25] Idle after reset
            bus_busy_flag               <= 1'b0;
            pin                         <= `TWS_R_PIN;
            arbitration_lost_flag       <= 1'b0;
            address_match_flag          <= 1'b0;
            general_call_flag           <= 1'b0;
            last_received_bit           <= 1'b0;
            addressed                   <= 1'b0;
            first_word                  <= 1'b0;
            bitn                        <= 4'h0;
            stop_req                    <= 1'b0;
            slv_hold                    <= 1'b0;
            hcnt                        <= 10'h000;
            scl_p                       <= 1'b1;
            sda_p                       <= 1'b1;
            scl_out                     <= 1'b0;
            sda_out                     <= 1'b0;
            scl_oe                      <= 1'b0;
            sda_oe                      <= 1'b0;
            bus_interrupt_request       <= 1'b0;
        end else begin
            scl_p                 <= scl_s;
            sda_p                 <= sda_s;
            scl_out               <= 1'b0;
            sda_out               <= 1'b0;
            bus_interrupt_request <= 1'b0;

            // Software writes
            if (wr & a_ctl1) begin
                bit_count_field <= pwdata[`TWS_F_BC_HI:`TWS_F_BC_LO];
                ack             <= pwdata[`TWS_B_ACK];
                sck             <= pwdata[`TWS_F_SCK_HI:`TWS_F_SCK_LO];
            end
            if (wr & a_oar) begin
                own_address_field           <= pwdata[`TWS_F_SA_HI:`TWS_F_SA_LO];
                address_recognition_disable <= pwdata[`TWS_B_ALS];
            end
            if (wr & a_ctl2) begin
                // [RQ15] Control-two write clears lost flag
                arbitration_lost_flag <= 1'b0;
                master_select         <= pwdata[`TWS_B_MST];
                transmitter_select    <= pwdata[`TWS_B_TRX];
                // [RQ11] Mode select
                operating_mode_field  <= pwdata[`TWS_F_MODE_HI:`TWS_F_MODE_LO];
                // [RQ10] Pending can only be set
                if (pwdata[`TWS_B_PIN])
                    pin <= 1'b1;
            end
            // [RQ3] Remember stop request
            if (stop_cmd)
                stop_req <= 1'b1;
            // [RQ9] Buffer access sets pending
            if (acc & a_dbuf) begin
                pin                   <= 1'b1;
                // [RQ15] Buffer access clears lost flag
                arbitration_lost_flag <= 1'b0;
                // [RQ16] Buffer access clears match
                address_match_flag    <= 1'b0;
                if (pwrite)
                    data_buffer <= pwdata[7:0];
            end

            // [RQ5] Busy on start
            if (st_det) begin
                bus_busy_flag     <= 1'b1;
                // [RQ23] Address byte always eight bits
                bit_count_field   <= 3'h0;
                // [RQ17] Start clears general call
                general_call_flag <= 1'b0;
                first_word        <= 1'b1;
                addressed         <= 1'b0;
                bitn              <= 4'h0;
            end
            // [RQ5] Idle on stop
            if (sp_det | ~on) begin
                bus_busy_flag      <= 1'b0;
                master_select      <= 1'b0;
                transmitter_select <= 1'b0;
                general_call_flag  <= 1'b0;
                addressed          <= 1'b0;
                first_word         <= 1'b0;
                bitn               <= 4'h0;
                stop_req           <= 1'b0;
            end

            // [RQ18] Sample line at every rise
            if (scl_rise)
                last_received_bit <= sda_s;
            if (scl_rise & bus_busy_flag & (bitn < wlen)) begin
                bitn <= bitn + 4'h1;
                if (bitn < dlen)
                    data_buffer <= {data_buffer[6:0], sda_s};
            end
            // [RQ14] Fall back to slave receiver
            if (lose) begin
                arbitration_lost_flag <= 1'b1;
                master_select         <= 1'b0;
                transmitter_select    <= 1'b0;
            end

            // Word end on the closing falling edge
            if (scl_fall & bus_busy_flag & (bitn == wlen)) begin
                bitn       <= 4'h0;
                first_word <= 1'b0;
                if (master_select) begin
                    // [RQ6] Master word done
                    pin                   <= 1'b0;
                    bus_interrupt_request <= 1'b1;
                    // [RQ21] Direction applied only when acknowledged
                    if (first_word & ack & ~last_received_bit)
                        transmitter_select <= ~data_buffer[0];
                end else if (first_word & ~address_recognition_disable) begin
                    // [RQ17] All-zero first byte
                    if (data_buffer == `TWS_GCALL)
                        general_call_flag <= 1'b1;
                    // [RQ7] Own address or general call
                    if (match) begin
                        addressed             <= 1'b1;
                        address_match_flag    <= 1'b1;
                        transmitter_select    <= data_buffer[0];
                        pin                   <= 1'b0;
                        bus_interrupt_request <= 1'b1;
                    end else if (arbitration_lost_flag) begin
                        pin                   <= 1'b0;
                        bus_interrupt_request <= 1'b1;
                    end
                end else if (addressed | address_recognition_disable | arbitration_lost_flag) begin
                    // [RQ16] First free-format word
                    if (first_word & address_recognition_disable)
                        address_match_flag <= 1'b1;
                    // [RQ7] Data word after match
                    pin                   <= 1'b0;
                    bus_interrupt_request <= 1'b1;
                end
            end

            // [RQ8] Hold clock while pending is zero
            if (~pin & on) begin
                slv_hold <= 1'b1;
                hcnt     <= 10'h000;
            // [RQ9] Release one low period after pending
            end else if (slv_hold) begin
                if (hcnt == last)
                    slv_hold <= 1'b0;
                else
                    hcnt <= hcnt + 10'h001;
            end

            // [RQ13] Clock drive ends with mastership
            scl_oe <= on & ~lose & (slv_hold | (state == S_LOW) | (state == S_STP1));

            // Data line drive
            if (~on | lose)
                sda_oe <= 1'b0;
            else if ((state == S_START) | (state == S_STP1) | (state == S_STP2))
                sda_oe <= 1'b1;
            else if ((state == S_STP3) | ~bus_busy_flag)
                sda_oe <= 1'b0;
            // [RQ1] Shift out the buffer
            else if (~scl_s)
                sda_oe <= next_sda;
        end
    end
endmodule // tws_core

/* File: rtl/tws_consts.vh */
// Register map, field positions, reset values and timing of the two-wire bus unit
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH
// ============================================================
// Register offsets (byte addresses)
`define TWS_A_CTL1     8'h00
`define TWS_A_DBUF     8'h04
`define TWS_A_OAR      8'h08
`define TWS_A_CTL2     8'h0C
`define TWS_A_CREG     8'h10
// ============================================================
// Field positions
`define TWS_F_BC_HI    7
`define TWS_F_BC_LO    5
`define TWS_B_ACK      4
`define TWS_F_SCK_HI   2
`define TWS_F_SCK_LO   0
`define TWS_F_SA_HI    7
`define TWS_F_SA_LO    1
`define TWS_B_ALS      0
`define TWS_B_MST      7
`define TWS_B_TRX      6
`define TWS_B_BB       5
`define TWS_B_PIN      4
`define TWS_F_MODE_HI  3
`define TWS_F_MODE_LO  2
`define TWS_B_SOFTWARE_RESET_BIT    0
// ============================================================
// Reset values
`define TWS_R_BC       3'h0
`define TWS_R_ACK      1'h0
`define TWS_R_SCK      3'h0
`define TWS_R_SA       7'h00
`define TWS_R_ALS      1'h0
`define TWS_R_DBUF     8'h00
`define TWS_R_MODE     2'h0
`define TWS_R_PIN      1'h1
// ============================================================
// Modes and timing
`define TWS_MODE_I2C   2'h2
`define TWS_GCALL      8'h00
`define TWS_HALF_MIN   10'h004
`endif

/* File: rtl/tws_sync.v */
// Two flip-flop synchroniser, one chain per bit
`timescale 1ns/1ps
module tws_sync #(
    parameter         W  = 1,
    parameter [W-1:0] RV = {W{1'b1}}
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    genvar i;
    // ============================================================
    // Per-bit chain
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg [1:0] st;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    st <= {RV[i], RV[i]};
                else
                    st <= {st[0], d[i]};
            end
            assign q[i] = st[1];
        end
    endgenerate
endmodule // tws_sync

/* File: test/tws_peer.sv */
// Slave device model on the far side of the two-wire bus
`timescale 1ns/1ps
module tws_peer #(
    parameter [6:0] ADDR = 7'h52
) (
    input  wire       scl,
    input  wire       sda,
    output reg        sda_low,
    output reg  [7:0] rx_byte
);
    integer   n = 0;
    reg [7:0] sh = 8'h00;
    initial sda_low = 1'b0;
    initial rx_byte = 8'h00;
    // Start restarts the bit count
    always @(negedge sda) if (scl) n = 0;
    always @(posedge scl) begin
        sh = {sh[6:0], sda};
        n = n + 1;
    end
    always @(negedge scl) begin
        sda_low = (n == 8) && (sh[7:1] == ADDR);
        if (n == 8) rx_byte = sh;
    end
endmodule // tws_peer

/* File: test/tws_checker.sv */
// Port assertions for the two-wire bus unit
`timescale 1ns/1ps
module tws_checker (
    input wire        clk,
    input wire        resetn,
    input wire        psel,
    input wire        penable,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        scl_out,
    input wire        scl_oe,
    input wire        sda_out,
    input wire        sda_oe,
    input wire        bus_interrupt_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire dbuf_done = psel && penable && pready && (paddr == 8'h04);
    sequence apb_setup; psel && !penable; endsequence
    sequence apb_access; psel && penable; endsequence
    // ============================================================
    // Register bus
    apb_wait_a: assert property (apb_setup ##1 apb_access |-> !pready ##1 pready)
        else $error("ready latency wrong");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    // ============================================================
    // Bus lines
    irq_pulse_a: assert property (bus_interrupt_request |=> !bus_interrupt_request)
        else $error("irq not a pulse");
    hold_low_a: assert property (bus_interrupt_request |-> ##2 scl_oe [*8])
        else $error("clock not held");
    release_low_a: assert property (dbuf_done && scl_oe |=> scl_oe [*3] ##[1:600] !scl_oe)
        else $error("clock release wrong");
    idle_lines_a: assert property (disable iff (1'b0) !resetn |-> !scl_oe && !sda_oe)
        else $error("line driven in reset");
    open_drain_a: assert property (!scl_out && !sda_out) else $error("line driven high");
endmodule // tws_checker
bind tws_core tws_checker chk_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .bus_interrupt_request(bus_interrupt_request));

/* File: test/tb_top.sv */
// Register level testbench of the two-wire bus unit
`timescale 1ns/1ps
module tb_top;
    reg         clk = 1'b0, resetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_low = 1'b0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0, r;
    reg         e;
    wire [31:0] prdata;
    wire        pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, peer_low;
    wire [7:0]  peer_byte;
    wire        scl = ~scl_oe;
    wire        sda = ~(sda_oe | peer_low | ext_low);
    integer     err_count = 0, comparisons = 0, i;
    always #25 clk = ~clk;
    tws_core dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .bus_interrupt_request(irq));
    tws_peer peer (.scl(scl), .sda(sda), .sda_low(peer_low), .rx_byte(peer_byte));
    // ============================================================
    // Tasks
    task give_verdict;
        begin
            $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task fail(input string m);
        begin
            $display("CHECK FAILED at %0t: %s", $time, m);
            err_count = err_count + 1;
        end
    endtask
    task xfer(input bit w, input [7:0] a, input [7:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'h0, d};
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (n == 50) begin
                fail("bus timeout");
                give_verdict;
            end
        end
    endtask
    task rd(input [7:0] a, input [31:0] x);
        begin
            xfer(1'b0, a, 8'h00);
            comparisons = comparisons + 1;
            if (r !== x) fail($sformatf("addr %h read %h expected %h", a, r, x));
        end
    endtask
    task poll(input [7:0] m, input [7:0] v);
        begin
            i = 0;
            xfer(1'b0, 8'h0C, 8'h00);
            while ((r[7:0] & m) !== v && i < 300) begin
                xfer(1'b0, 8'h0C, 8'h00);
                i = i + 1;
            end
            if (i == 300) begin
                fail("status wait timeout");
                give_verdict;
            end
        end
    endtask
    task wait_irq;
        begin
            i = 0;
            while (irq !== 1'b1 && i < 3000) begin
                @(posedge clk);
                i = i + 1;
            end
            if (i == 3000) begin
                fail("no interrupt");
                give_verdict;
            end
        end
    endtask
    // ============================================================
    // Main sequence
    initial begin
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h0C, 32'h10);
        rd(8'h14, 32'h0);
        comparisons = comparisons + 1;
        if (e !== 1'b1) fail("unmapped address accepted");
        xfer(1'b1, 8'h0C, 8'hF0);
        rd(8'h0C, 32'h10);
        $display("Test reset done");
        xfer(1'b1, 8'h00, 8'h10);
        xfer(1'b1, 8'h08, 8'h54);
        xfer(1'b1, 8'h0C, 8'h18);
        xfer(1'b1, 8'h04, 8'hA4);
        rd(8'h0C, 32'h10);
        xfer(1'b1, 8'h0C, 8'hF8);
        wait_irq;
        rd(8'h0C, 32'hE0);
        comparisons = comparisons + 1;
        if (peer_byte !== 8'hA4) fail("address byte wrong");
        xfer(1'b1, 8'h04, 8'h3C);
        wait_irq;
        rd(8'h0C, 32'hE1);
        xfer(1'b1, 8'h0C, 8'hE8);
        rd(8'h0C, 32'hE1);
        xfer(1'b1, 8'h0C, 8'hD8);
        poll(8'h20, 8'h00);
        rd(8'h0C, 32'h10);
        $display("Test master write done");
        xfer(1'b1, 8'h04, 8'hFE);
        xfer(1'b1, 8'h0C, 8'hF8);
        i = 0;
        while (scl !== 1'b0 && i < 500) begin
            @(posedge clk);
            i = i + 1;
        end
        if (i == 500) begin
            fail("no clock low");
            give_verdict;
        end
        ext_low <= 1'b1;
        poll(8'h08, 8'h08);
        rd(8'h0C, 32'h38);
        comparisons = comparisons + 1;
        if ({scl_oe, sda_oe} !== 2'b00) fail("lines still driven");
        xfer(1'b1, 8'h0C, 8'h18);
        rd(8'h0C, 32'h30);
        ext_low <= 1'b0;
        poll(8'h20, 8'h00);
        $display("Test arbitration done");
        xfer(1'b1, 8'h10, 8'h01);
        rd(8'h00, 32'h0);
        rd(8'h0C, 32'h10);
        rd(8'h10, 32'h0);
        $display("Test software reset done");
        give_verdict;
    end
endmodule // tb_top
